// file: rtl/phy_port_status_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Partner pause at bit 10, mirrored status bit 4
// - Partner 100M full/half bits 8,7 mirrored
// - Partner 10M full/half bits 6,5 mirrored
// - Polarity reversal bit 5, mirrored status bit 13
// - Force link pass shared bit, reset 0
// - Low-power 10M disable bit, reset 1
// - Remote loopback shared bit, reset 0
// - Lamp override codes 100 to 111
// - Override top bit 0 follows lamp mode
// - Cable test outcome in bits 14:13
// - Write 1 starts test, self-clears when done
// - Short under ten metres flag bit 15
// - Nine-bit fault distance in bits 8:0
// - Empty offset windows hold no registers
module phy_port_status_control_regs
  import phy_port_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RESET_N,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [1:0]        REG_BE,
  input  wire logic [15:0]       REG_WDATA,
  output logic [15:0]            REG_RDATA,
  output logic                   REG_RVALID,
  input  wire logic [4:0]        LP_ABILITY,
  input  wire logic              RX_POLARITY_REV,
  input  wire logic              MDIX_STATE,
  input  wire logic [1:0]        LED_MODE_SEL,
  input  wire logic              LINK_UP,
  input  wire logic              LINK_ACTIVITY,
  input  wire logic              SPEED_100,
  input  wire logic              FULL_DUPLEX,
  input  wire logic              CT_DONE,
  input  wire logic [1:0]        CT_RESULT,
  input  wire logic              CT_SHORT_10M,
  input  wire logic [8:0]        CT_COUNT,
  output logic                   CT_KICK,
  output logic                   FORCE_LINK_PASS,
  output logic                   EEE10_DISABLE,
  output logic                   REMOTE_LOOPBACK,
  output logic [15:0]            PORT_STATUS_MIRROR,
  output logic                   PORT_LAMP_A,
  output logic                   PORT_LAMP_B,
  output logic [15:0]            CTRL4_OUT
);
  cable_test_if ct ();

  logic [6:0]  stat_s1_q;
  logic [6:0]  stat_s2_q;
  logic [4:0]  abil;
  logic        pol;
  logic        mdix;
  logic        force_q;
  logic        eee_dis_q;
  logic        loop_q;
  logic        sc_rsv0_q;
  logic [2:0]  led_ovr_q;
  logic [11:0] led_rsv_q;
  logic        diag_rsv10_q;
  logic [15:0] ctrl4_q;
  logic [15:0] rdata_d;
  logic        wr_lo;
  logic        wr_hi;
  logic        hit_special;
  logic        hit_led;
  logic        hit_diag;
  logic        hit_ctrl4;

  // Line-side status arrives from the analog front end, so synchronise it
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      stat_s1_q <= 7'h00;
      stat_s2_q <= 7'h00;
    end else begin
      stat_s1_q <= {MDIX_STATE, RX_POLARITY_REV, LP_ABILITY};
      stat_s2_q <= stat_s1_q;
    end
  end
  assign abil = stat_s2_q[4:0];
  assign pol  = stat_s2_q[5];
  assign mdix = stat_s2_q[6];

  // Status register sees exactly the flops that the partner register reads
  assign PORT_STATUS_MIRROR = {2'b00, pol, 5'b00000, mdix, 2'b00, abil};

  assign wr_lo       = REG_WR & REG_BE[0];
  assign wr_hi       = REG_WR & REG_BE[1];
  assign hit_special = (REG_ADDR == OFS_SPECIAL);
  assign hit_led     = (REG_ADDR == OFS_LED);
  assign hit_diag    = (REG_ADDR == OFS_DIAG);
  assign hit_ctrl4   = (REG_ADDR == OFS_CTRL4);

  // Force link: one flop behind two addresses, so no copy can drift
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      force_q <= 1'b0;
    end else if (hit_diag && wr_hi) begin
      force_q <= REG_WDATA[CD_FORCE];
    end else if (hit_special && wr_lo) begin
      force_q <= REG_WDATA[SC_FORCE];
    end
  end

  // Remote loopback: same shared-flop scheme
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      loop_q <= 1'b0;
    end else if (hit_diag && wr_hi) begin
      loop_q <= REG_WDATA[CD_LOOP];
    end else if (hit_special && wr_lo) begin
      loop_q <= REG_WDATA[SC_LOOP];
    end
  end

  // Special register writable bits; upper byte reads zero and ignores writes
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      eee_dis_q <= SC_EEE_RST;
      sc_rsv0_q <= 1'b0;
    end else if (hit_special && wr_lo) begin
      eee_dis_q <= REG_WDATA[SC_EEE];
      sc_rsv0_q <= REG_WDATA[SC_RSV0];
    end
  end

  // Lamp override field and its writable reserved neighbours
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      led_ovr_q <= LED_RST;
      led_rsv_q <= 12'h000;
    end else if (hit_led) begin
      if (wr_hi) begin
        led_ovr_q       <= REG_WDATA[LED_LO+2:LED_LO];
        led_rsv_q[11:8] <= REG_WDATA[11:8];
      end
      if (wr_lo) begin
        led_rsv_q[7:0] <= REG_WDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      diag_rsv10_q <= CD_RSV10_RST;
    end else if (hit_diag && wr_hi) begin
      diag_rsv10_q <= REG_WDATA[CD_RSV10];
    end
  end

  // Start only on a 1 in the upper byte; a 0 cannot abort a running test
  assign ct.start = hit_diag & wr_hi & REG_WDATA[CD_START];

  // Restart bit acts for one cycle then drops by itself
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ctrl4_q <= CTRL4_RST;
    end else begin
      ctrl4_q[CTRL4_RESTART] <= 1'b0;
      if (hit_ctrl4 && wr_hi) begin
        ctrl4_q[15:8] <= REG_WDATA[15:8];
      end
      if (hit_ctrl4 && wr_lo) begin
        ctrl4_q[7:0] <= REG_WDATA[7:0];
      end
    end
  end

  // Read-only fields are rebuilt from live state, so writes cannot touch them
  always_comb begin
    rdata_d = 16'h0000;
    if (REG_ADDR == OFS_PARTNER) begin
      rdata_d = {5'h00, abil[4], 1'b0, abil[3:0], PA_LOW_RST};
    end else if (hit_special) begin
      rdata_d = {10'h000, pol, mdix, force_q, eee_dis_q, loop_q, sc_rsv0_q};
    end else if (hit_led) begin
      rdata_d = {1'b0, led_ovr_q, led_rsv_q};
    end else if (hit_diag) begin
      rdata_d = {ct.short10, ct.result, ct.running, force_q, diag_rsv10_q, loop_q, ct.count};
    end else if (hit_ctrl4) begin
      rdata_d = ctrl4_q;
    end else begin
      rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  assign FORCE_LINK_PASS = force_q;
  assign EEE10_DISABLE   = eee_dis_q;
  assign REMOTE_LOOPBACK = loop_q;
  assign CTRL4_OUT       = ctrl4_q;

  cable_test_ctrl u_cable_test (
    .clk        (REF_CLK),
    .rst_n      (RESET_N),
    .ct         (ct.ctrl),
    .done_pin   (CT_DONE),
    .result_pin (CT_RESULT),
    .short_pin  (CT_SHORT_10M),
    .count_pin  (CT_COUNT),
    .kick       (CT_KICK)
  );

  lamp_drive u_lamp (
    .clk      (REF_CLK),
    .rst_n    (RESET_N),
    .override (led_ovr_q),
    .mode     (LED_MODE_SEL),
    .link     (LINK_UP),
    .act      (LINK_ACTIVITY),
    .spd      (SPEED_100),
    .dup      (FULL_DUPLEX),
    .lamp_a   (PORT_LAMP_A),
    .lamp_b   (PORT_LAMP_B)
  );

  pause_mirror_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && REG_ADDR == OFS_PARTNER) |=> (REG_RDATA[PA_PAUSE] == $past(PORT_STATUS_MIRROR[PS_PAUSE])))
    else $error("partner pause differs from status mirror");
  ability_mirror_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && REG_ADDR == OFS_PARTNER) |=> (REG_RDATA[8:5] == $past(PORT_STATUS_MIRROR[3:0])))
    else $error("partner speed abilities differ from status mirror");
  partner_low_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && REG_ADDR == OFS_PARTNER) |=> (REG_RDATA[15:11] == 5'h00 && REG_RDATA[4:0] == PA_LOW_RST))
    else $error("partner register fixed fields wrong");
  polarity_mirror_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && hit_special) |=> (REG_RDATA[SC_POL] == $past(PORT_STATUS_MIRROR[PS_POL])))
    else $error("polarity differs from status mirror");
  force_alias_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (hit_diag && wr_hi) ##1 !REG_WR ##1 (REG_RD && hit_special)
    |=> (REG_RDATA[SC_FORCE] == $past(REG_WDATA[CD_FORCE], 3)))
    else $error("force link alias not visible");
  loop_alias_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (hit_special && wr_lo && !(REG_WR && REG_BE[1])) |=> (REMOTE_LOOPBACK == $past(REG_WDATA[SC_LOOP])))
    else $error("remote loopback write lost");
  eee_reset_a: assert property (@(posedge REF_CLK)
    !RESET_N |=> (EEE10_DISABLE && !FORCE_LINK_PASS && !REMOTE_LOOPBACK))
    else $error("control reset values wrong");
  gap_read_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && ((REG_ADDR >= GAP_A_LO && REG_ADDR <= GAP_A_HI) || (REG_ADDR >= GAP_C_LO && REG_ADDR <= GAP_C_HI)))
    |=> (REG_RDATA == 16'h0000))
    else $error("empty window returned data");
  start_ignored_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (hit_diag && wr_hi && !REG_WDATA[CD_START] && !ct.running) |=> !ct.running)
    else $error("zero write started cable test");

  // Either alias location must steer the one output flop
  force_special_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (hit_special && wr_lo) |=> (FORCE_LINK_PASS == $past(REG_WDATA[SC_FORCE])))
    else $error("force link write via special register lost");
  force_diag_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (hit_diag && wr_hi) |=> (FORCE_LINK_PASS == $past(REG_WDATA[CD_FORCE])))
    else $error("force link write via diagnostic register lost");
  loop_diag_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (hit_diag && wr_hi) |=> (REMOTE_LOOPBACK == $past(REG_WDATA[CD_LOOP])))
    else $error("remote loopback write via diagnostic register lost");
  eee_write_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (hit_special && wr_lo) |=> (EEE10_DISABLE == $past(REG_WDATA[SC_EEE])))
    else $error("low-power disable write lost");
  special_upper_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && hit_special) |=> (REG_RDATA[15:6] == 10'h000))
    else $error("special register upper bits not zero");
  lamp_top_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && hit_led) |=> !REG_RDATA[15])
    else $error("lamp register top bit not zero");
  gap_b_read_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && REG_ADDR >= GAP_B_LO && REG_ADDR <= GAP_B_HI) |=> (REG_RDATA == 16'h0000))
    else $error("second empty window returned data");
  result_read_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && hit_diag) |=> (REG_RDATA[15:13] == $past({ct.short10, ct.result})))
    else $error("cable test outcome misplaced in read data");
  count_read_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && hit_diag) |=> (REG_RDATA[CNT_W-1:0] == $past(ct.count)))
    else $error("fault distance misplaced in read data");
  busy_read_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (REG_RD && hit_diag) |=> (REG_RDATA[CD_START] == $past(ct.running)))
    else $error("test start bit does not show a running test");
  kick_pulse_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CT_KICK |=> !CT_KICK)
    else $error("test kick longer than one cycle");
  read_valid_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    1'b1 |=> (REG_RVALID == $past(REG_RD)))
    else $error("read valid not one cycle after read strobe");
  read_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  restart_clear_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (CTRL4_OUT[CTRL4_RESTART] && !(hit_ctrl4 && wr_hi && REG_WDATA[CTRL4_RESTART]))
    |=> !CTRL4_OUT[CTRL4_RESTART])
    else $error("restart bit did not clear itself");
endmodule : phy_port_status_control_regs
`default_nettype wire

// file: rtl/phy_port_pkg.sv
package phy_port_pkg;
  localparam int          ADDR_W       = 8;
  // Register byte offsets
  localparam logic [7:0]  OFS_PARTNER  = 8'h56;
  localparam logic [7:0]  OFS_SPECIAL  = 8'h66;
  localparam logic [7:0]  OFS_LED      = 8'h6C;
  localparam logic [7:0]  OFS_DIAG     = 8'h7C;
  localparam logic [7:0]  OFS_CTRL4    = 8'h7E;
  // Empty windows inside the block
  localparam logic [7:0]  GAP_A_LO     = 8'h58;
  localparam logic [7:0]  GAP_A_HI     = 8'h65;
  localparam logic [7:0]  GAP_B_LO     = 8'h68;
  localparam logic [7:0]  GAP_B_HI     = 8'h6B;
  localparam logic [7:0]  GAP_C_LO     = 8'h6E;
  localparam logic [7:0]  GAP_C_HI     = 8'h7B;
  // Partner ability fields
  localparam int          PA_PAUSE     = 10;
  localparam int          PA_ABIL_LO   = 5;
  localparam logic [4:0]  PA_LOW_RST   = 5'h01;
  // Special control and status fields
  localparam int          SC_POL       = 5;
  localparam int          SC_MDIX      = 4;
  localparam int          SC_FORCE     = 3;
  localparam int          SC_EEE       = 2;
  localparam int          SC_LOOP      = 1;
  localparam int          SC_RSV0      = 0;
  localparam logic        SC_EEE_RST   = 1'b1;
  // Lamp override fields
  localparam int          LED_LO       = 12;
  localparam logic [2:0]  LED_RST      = 3'h0;
  localparam logic [2:0]  LED_OFF_BOTH = 3'h4;
  localparam logic [2:0]  LED_A_ONLY   = 3'h5;
  localparam logic [2:0]  LED_B_ONLY   = 3'h6;
  localparam logic [2:0]  LED_ON_BOTH  = 3'h7;
  // Cable diagnostic fields
  localparam int          CD_SHORT     = 15;
  localparam int          CD_RES_LO    = 13;
  localparam int          CD_START     = 12;
  localparam int          CD_FORCE     = 11;
  localparam int          CD_RSV10     = 10;
  localparam int          CD_LOOP      = 9;
  localparam int          CNT_W        = 9;
  localparam logic        CD_RSV10_RST = 1'b1;
  // Fourth port control register
  localparam logic [15:0] CTRL4_RST    = 16'h00FF;
  localparam int          CTRL4_RESTART = 13;
  // Port status mirror positions
  localparam int          PS_POL       = 13;
  localparam int          PS_MDIX      = 7;
  localparam int          PS_PAUSE     = 4;
  typedef enum logic [1:0] {RES_NORMAL = 2'h0, RES_OPEN = 2'h1, RES_SHORT = 2'h2, RES_FAIL = 2'h3} ct_result_t;
  typedef enum logic {CT_IDLE = 1'b0, CT_RUN = 1'b1} ct_state_t;
endpackage : phy_port_pkg

// file: rtl/cable_test_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cable_test_if;
  logic             start;
  logic             running;
  logic [1:0]       result;
  logic             short10;
  logic [8:0]       count;
  modport ctrl (input start, output running, output result, output short10, output count);
  modport regs (output start, input running, input result, input short10, input count);
endinterface : cable_test_if
`default_nettype wire

// file: rtl/cable_test_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cable_test_ctrl
  import phy_port_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  cable_test_if.ctrl        ct,
  input  wire logic         done_pin,
  input  wire logic [1:0]   result_pin,
  input  wire logic         short_pin,
  input  wire logic [8:0]   count_pin,
  output logic              kick
);
  logic [12:0] s1_q;
  logic [12:0] s2_q;
  logic        done3_q;
  logic        done_edge;
  ct_state_t   state_q;

  // Results travel in the same pipeline as done, so they settle together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q    <= 13'h0000;
      s2_q    <= 13'h0000;
      done3_q <= 1'b0;
    end else begin
      s1_q    <= {done_pin, short_pin, result_pin, count_pin};
      s2_q    <= s1_q;
      done3_q <= s2_q[12];
    end
  end
  assign done_edge = s2_q[12] & ~done3_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= CT_IDLE;
      kick    <= 1'b0;
    end else begin
      kick <= 1'b0;
      case (state_q)
        CT_IDLE: if (ct.start) begin
          state_q <= CT_RUN;
          kick    <= 1'b1;
        end
        CT_RUN: if (done_edge) state_q <= CT_IDLE;
        default: state_q <= CT_IDLE;
      endcase
    end
  end
  assign ct.running = (state_q == CT_RUN);

  // Old results stay readable until the new ones land with the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ct.result  <= RES_NORMAL;
      ct.short10 <= 1'b0;
      ct.count   <= 9'h000;
    end else if (state_q == CT_RUN && done_edge) begin
      ct.result  <= s2_q[10:9];
      ct.short10 <= s2_q[11];
      ct.count   <= s2_q[8:0];
    end
  end

  start_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == CT_IDLE && ct.start) |=> (ct.running && kick) ##1 !kick)
    else $error("cable test start not taken");
  result_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ct.running && !done_edge) |=> ($stable(ct.result) && $stable(ct.count) && $stable(ct.short10)))
    else $error("cable test result moved during test");
  result_land_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ct.running && done_edge) |=> (!ct.running && ct.count == $past(s2_q[8:0]) && ct.short10 == $past(s2_q[11])))
    else $error("cable test result not captured at completion");
endmodule : cable_test_ctrl
`default_nettype wire

// file: rtl/lamp_drive.sv
`timescale 1ns/1ps
`default_nettype none
module lamp_drive
  import phy_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  override,
  input  wire logic [1:0]  mode,
  input  wire logic        link,
  input  wire logic        act,
  input  wire logic        spd,
  input  wire logic        dup,
  output logic             lamp_a,
  output logic             lamp_b
);
  logic a_d;
  logic b_d;
  logic link_act;

  // Lamp goes dark during activity so traffic shows as flicker
  assign link_act = link & ~act;

  always_comb begin
    a_d = 1'b0;
    b_d = 1'b0;
    if (override[2]) begin
      a_d = override[0];
      b_d = override[1];
    end else begin
      case (mode)
        2'h0: begin a_d = link_act; b_d = spd; end
        2'h1: begin a_d = link;     b_d = act; end
        2'h2: begin a_d = link_act; b_d = dup; end
        default: begin a_d = link;  b_d = spd; end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lamp_a <= 1'b0;
      lamp_b <= 1'b0;
    end else begin
      lamp_a <= a_d;
      lamp_b <= b_d;
    end
  end

  lamp_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    (override == LED_A_ONLY) |=> (lamp_a && !lamp_b))
    else $error("lamp override 101 not applied");
  lamp_dark_a: assert property (@(posedge clk) disable iff (!rst_n)
    (override == LED_OFF_BOTH) |=> (!lamp_a && !lamp_b))
    else $error("lamp override 100 not applied");
  lamp_b_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (override == LED_B_ONLY) |=> (!lamp_a && lamp_b))
    else $error("lamp override 110 not applied");
  lamp_both_a: assert property (@(posedge clk) disable iff (!rst_n)
    (override == LED_ON_BOTH) |=> (lamp_a && lamp_b))
    else $error("lamp override 111 not applied");
  lamp_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!override[2] && mode == 2'h1) |=> (lamp_a == $past(link) && lamp_b == $past(act)))
    else $error("lamp mode selection not followed");
endmodule : lamp_drive
`default_nettype wire

// file: bench/cable_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module cable_front_model (
  input  wire logic       clk,
  input  wire logic       kick,
  input  wire logic [1:0] want_res,
  input  wire logic       want_sh,
  input  wire logic [8:0] want_cnt,
  input  wire logic [7:0] want_dly,
  output logic            done,
  output logic [1:0]      res,
  output logic            sh,
  output logic [8:0]      cnt
);
  logic [7:0] left;
  initial begin
    done = 1'b0;
    {res, sh, cnt} = 12'h000;
    left = 8'h00;
  end
  // Pins churn while the test runs, so a block that samples early sees junk
  always @(posedge clk) begin
    if (kick) begin
      done <= 1'b0;
      left <= want_dly;
      {res, sh, cnt} <= ~{res, sh, cnt};
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
      if (left > 8'h04) begin
        {res, sh, cnt} <= ~{res, sh, cnt};
      end
      if (left == 8'h04) begin
        {res, sh, cnt} <= {want_res, want_sh, want_cnt};
      end
      if (left == 8'h01) begin
        done <= 1'b1;
      end
    end
  end
endmodule : cable_front_model
`default_nettype wire

// file: bench/phy_port_status_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module phy_port_status_control_regs_test;
  import phy_port_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [1:0]  be;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic [4:0]  ability;
  logic        pol;
  logic        mdix;
  logic [1:0]  mode;
  logic [3:0]  lnk;
  logic        done;
  logic [1:0]  res;
  logic        sh;
  logic [8:0]  cnt;
  logic        kick;
  logic        fpass;
  logic        eee;
  logic        loopb;
  logic [15:0] mirror;
  logic        lamp_a;
  logic        lamp_b;
  logic [1:0]  want_res;
  logic        want_sh;
  logic [8:0]  want_cnt;
  logic [7:0]  want_dly;
  logic        kick_seen;
  logic [15:0] got;
  logic [15:0] prev;
  logic [15:0] ctrl4;
  logic [7:0]  gaps [6] = '{8'h58, 8'h65, 8'h68, 8'h6B, 8'h6E, 8'h7B};
  logic [8:0]  cnts [4] = '{9'h000, 9'h1FF, 9'h019, 9'h0AA};
  int          n_errors;
  int          n_checks;

  phy_port_status_control_regs u_dut (
    .REF_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_BE(be), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .LP_ABILITY(ability), .RX_POLARITY_REV(pol), .MDIX_STATE(mdix), .LED_MODE_SEL(mode),
    .LINK_UP(lnk[3]), .LINK_ACTIVITY(lnk[2]), .SPEED_100(lnk[1]), .FULL_DUPLEX(lnk[0]),
    .CT_DONE(done), .CT_RESULT(res), .CT_SHORT_10M(sh), .CT_COUNT(cnt), .CT_KICK(kick),
    .FORCE_LINK_PASS(fpass), .EEE10_DISABLE(eee), .REMOTE_LOOPBACK(loopb),
    .PORT_STATUS_MIRROR(mirror), .PORT_LAMP_A(lamp_a), .PORT_LAMP_B(lamp_b), .CTRL4_OUT(ctrl4)
  );
  cable_front_model u_front (
    .clk(clk), .kick(kick), .want_res(want_res), .want_sh(want_sh), .want_cnt(want_cnt),
    .want_dly(want_dly), .done(done), .res(res), .sh(sh), .cnt(cnt)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles

  // Kick is sampled on the falling edge half a cycle after the write edge, while it stands
  task automatic reg_wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    be = b;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    kick_seen = kick;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0, rvalid});
    d = rdata;
  endtask : reg_rd

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    reg_rd(a, v);
    chk(what, exp, v);
  endtask : rd_chk

  function automatic logic [15:0] lamp_exp(input logic [1:0] m, input logic [3:0] l);
    logic a;
    logic b;
    a = m[0] ? l[3] : (l[3] & ~l[2]);
    case (m)
      2'h1: b = l[2];
      2'h2: b = l[0];
      default: b = l[1];
    endcase
    return {14'h0, a, b};
  endfunction : lamp_exp

  initial begin
    n_errors = 0;
    n_checks = 0;
    {rst_n, wr, rd, pol, mdix} = 5'h00;
    {addr, be, wdata, ability, mode} = 33'h0;
    lnk = 4'hD;
    {want_res, want_sh, want_cnt, kick_seen} = 13'h0;
    want_dly = 8'h06;
    cycles(20);
    rst_n = 1'b1;
    rd_chk("partner", OFS_PARTNER, 16'h0001);
    rd_chk("special", OFS_SPECIAL, 16'h0004);
    rd_chk("lamp reg", OFS_LED, 16'h0000);
    rd_chk("diag", OFS_DIAG, 16'h0400);
    chk("outs", 16'h0002, {13'h0, fpass, eee, loopb});
    for (int i = 0; i < 5; i++) begin
      ability = 5'h01 << i;
      cycles(5);
      chk("mirror", 16'h0001 << i, mirror);
      rd_chk("partner", OFS_PARTNER, (i == 4) ? 16'h0401 : (16'h0001 | (16'h0020 << i)));
    end
    reg_wr(OFS_PARTNER, 2'h3, 16'hFFFF);
    rd_chk("partner ro", OFS_PARTNER, 16'h0401);
    {ability, pol, mdix} = 7'h03;
    cycles(5);
    chk("mirror", 16'h2080, mirror);
    reg_wr(OFS_SPECIAL, 2'h3, 16'hFFC0);
    rd_chk("special", OFS_SPECIAL, 16'h0030);
    chk("eee", 16'h0000, {15'h0, eee});
    reg_wr(OFS_SPECIAL, 2'h1, 16'h000E);
    rd_chk("special", OFS_SPECIAL, 16'h003E);
    rd_chk("diag alias", OFS_DIAG, 16'h0E00);
    chk("outs", 16'h0007, {13'h0, fpass, eee, loopb});
    reg_wr(OFS_DIAG, 2'h2, 16'h0400);
    rd_chk("special alias", OFS_SPECIAL, 16'h0034);
    chk("outs", 16'h0002, {13'h0, fpass, eee, loopb});
    reg_wr(OFS_DIAG, 2'h1, 16'h01FF);
    rd_chk("diag ro", OFS_DIAG, 16'h0400);
    foreach (gaps[k]) begin
      reg_wr(gaps[k], 2'h3, 16'hFFFF);
      rd_chk("gap", gaps[k], 16'h0000);
    end
    chk("ctrl4 out", 16'h00FF, ctrl4);
    rd_chk("ctrl4", OFS_CTRL4, 16'h00FF);
    reg_wr(OFS_CTRL4, 2'h3, 16'h2A55);
    chk("restart", 16'h2A55, ctrl4);
    rd_chk("ctrl4", OFS_CTRL4, 16'h0A55);
    for (int c = 4; c < 8; c++) begin
      reg_wr(OFS_LED, 2'h2, 16'h8000 | (16'(c) << 12));
      cycles(2);
      chk("lamps", {14'h0, c[0], c[1]}, {14'h0, lamp_a, lamp_b});
      rd_chk("lamp reg", OFS_LED, 16'(c) << 12);
    end
    reg_wr(OFS_LED, 2'h2, 16'h3000);
    for (int m = 0; m < 8; m++) begin
      mode = 2'(m);
      lnk = m[2] ? 4'hA : 4'hD;
      cycles(2);
      chk("lamps", lamp_exp(2'(m), lnk), {14'h0, lamp_a, lamp_b});
    end
    prev = 16'h0400;
    for (int t = 0; t < 4; t++) begin
      want_res = 2'(t);
      want_sh = (t == 2);
      want_cnt = cnts[t];
      want_dly = t[0] ? 8'h28 : 8'h06;
      reg_wr(OFS_DIAG, 2'h2, 16'h1400);
      chk("kick", 16'h0001, {15'h0, kick_seen});
      reg_wr(OFS_DIAG, 2'h2, 16'h1400);
      chk("kick while busy", 16'h0000, {15'h0, kick_seen});
      got = 16'h1000;
      for (int p = 0; p < 40 && got[12]; p++) begin
        reg_rd(OFS_DIAG, got);
        if (got[12]) chk("held", prev | 16'h1000, got);
      end
      if (got[12]) begin
        chk("test end", 16'h0000, 16'h1000);
        stop_test();
      end
      prev = {want_sh, want_res, 4'h2, want_cnt};
      chk("result", prev, got);
      chk("short", {15'h0, want_sh}, {15'h0, got[15]});
    end
    stop_test();
  end
endmodule : phy_port_status_control_regs_test
`default_nettype wire
